// ==== iflsq_sequencer.sv ====
// Flash programming sequencer: SFR registers, timed-access unlock,
// access checks and the sequence that drives the flash array.
// Assumes flash array, CPU and chip control logic share clk_i; the
// oscillator ready level arrives from another clock and is synchronised.
//
// Overview of operation
// - Command byte: area, OE, CE, function
// - Address high byte gives bits 15:8
// - Address low byte gives bits 7:0
// - Data byte in; read result left there
// - Go bit starts operation, CPU held
// - Go bit self-clears, reads as zero
// - Area 00 app, 01 loader, 11 config
// - Codes: erase 0010, program 0001, read 0000
// - Config erase clears all, low byte ignored
// - Erase acts on 256-byte aligned pages
// - Needs oscillator; enable off blocks triggers
// - External code execution refuses, sets fault
// - Config access only from loader code
// - Config applies after reset; boot select not soft
// - Lock bit never blocks programming
// - App and loader may read themselves
// - Trigger write needs timed-access unlock
// - Illegal target sets sticky fault flag
// - Loader writes from app need update enable
`timescale 1ns/1ps
`default_nettype none
module iflsq_sequencer #(
   parameter int APP_BYTES    = 65536,
   parameter int LOADER_BYTES = 4096,
   parameter int CFG_BYTES    = 4
) (
   input  wire logic                     clk_i,
   input  wire logic                     rst_b_i,
   input  wire logic [7:0]               sfr_addr_i,
   input  wire logic [7:0]               sfr_wdata_i,
   input  wire logic                     sfr_wr_i,
   input  wire logic                     sfr_rd_i,
   output logic      [7:0]               sfr_rdata_o,
   input  wire logic                     prog_enable_i,
   input  wire logic                     loader_update_enable_i,
   input  wire logic                     fault_clear_i,
   input  wire iflsq_pkg::iflsq_exec_t   exec_area_i,
   input  wire logic                     soft_reset_cause_i,
   input  wire logic [7:0]               cfg0_stored_i,
   input  wire logic                     rc_ready_i,
   output logic                          rc_osc_en_o,
   output logic                          cpu_hold_o,
   output logic                          programming_fault_flag_o,
   output logic                          key_unlocked_o,
   output logic [7:0]                    cfg0_active_o,
   output logic                          flash_req_o,
   output iflsq_pkg::iflsq_op_t          flash_op_o,
   output logic [17:0]                   flash_addr_o,
   output logic [7:0]                    flash_wdata_o,
   input  wire logic [7:0]               flash_rdata_i,
   input  wire logic                     flash_done_i
);
   initial begin
      if (APP_BYTES < 256 || APP_BYTES > 65536 || LOADER_BYTES < 256
          || LOADER_BYTES > 65536 || CFG_BYTES < 1 || CFG_BYTES > 256) begin
         $error("iflsq_sequencer: area sizes out of range");
      end
   end

   localparam logic [16:0] APP_LIMIT    = 17'(APP_BYTES);
   localparam logic [16:0] LOADER_LIMIT = 17'(LOADER_BYTES);
   localparam logic [16:0] CFG_LIMIT    = 17'(CFG_BYTES);

   typedef enum logic [1:0] {
      IFLSQ_IDLE,
      IFLSQ_WAIT_OSC,
      IFLSQ_ACCESS,
      IFLSQ_FINISH
   } iflsq_state_t;

   // Reset release through two flops
   logic rst_sync1_reg;
   logic rst_b_reg;
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rst_sync1_reg <= 1'b0;
         rst_b_reg     <= 1'b0;
      end else begin
         rst_sync1_reg <= 1'b1;
         rst_b_reg     <= rst_sync1_reg;
      end
   end

   // Oscillator ready comes from the RC domain
   logic rc_sync1_reg;
   logic rc_ready_reg;
   always_ff @(posedge clk_i or negedge rst_b_reg) begin
      if (!rst_b_reg) begin
         rc_sync1_reg <= 1'b0;
         rc_ready_reg <= 1'b0;
      end else begin
         rc_sync1_reg <= rc_ready_i;
         rc_ready_reg <= rc_sync1_reg;
      end
   end

   function automatic logic hit(input logic [7:0] ofs);
      hit = (sfr_addr_i == ofs);
   endfunction

   logic [7:0]   cmd_reg;
   logic [7:0]   addr_hi_reg;
   logic [7:0]   addr_lo_reg;
   logic [7:0]   data_reg;
   logic [1:0]   key_stage_reg;
   logic         fault_reg;
   iflsq_state_t state_reg;
   iflsq_state_t state_next;
   logic         trigger;
   logic         refused;
   logic         standby;
   logic         access_ok;

   // Command byte decode
   wire logic [1:0] area = cmd_reg[iflsq_pkg::AREA_HI:iflsq_pkg::AREA_LO];
   wire logic [3:0] func = cmd_reg[iflsq_pkg::FUNC_HI:iflsq_pkg::FUNC_LO];
   wire logic [15:0] addr16 = {addr_hi_reg, addr_lo_reg};
   wire logic writes = (func == iflsq_pkg::FUNC_PROGRAM) ||
                       (func == iflsq_pkg::FUNC_ERASE);
   wire logic known_func = writes || (func == iflsq_pkg::FUNC_READ);

   // Timed-access unlock sequence
   // AA then 55
   always_ff @(posedge clk_i or negedge rst_b_reg) begin
      if (!rst_b_reg) begin
         key_stage_reg <= 2'h0;
      end else if (sfr_wr_i) begin
         if (hit(iflsq_pkg::KEY_OFS) && sfr_wdata_i == iflsq_pkg::KEY_FIRST) begin
            key_stage_reg <= 2'h1;
         end else if (hit(iflsq_pkg::KEY_OFS) && key_stage_reg == 2'h1
                      && sfr_wdata_i == iflsq_pkg::KEY_SECOND) begin
            key_stage_reg <= 2'h2;
         end else begin
            key_stage_reg <= 2'h0;
         end
      end
   end

   assign trigger = sfr_wr_i && hit(iflsq_pkg::TRIG_OFS) && key_stage_reg == 2'h2
                    && sfr_wdata_i[iflsq_pkg::GO_BIT] && prog_enable_i
                    && state_reg == IFLSQ_IDLE;

   assign standby = cmd_reg[iflsq_pkg::OE_BIT] && cmd_reg[iflsq_pkg::CE_BIT];

   // Access legality; lock bit is deliberately not consulted
   always_comb begin
      access_ok = 1'b1;
      unique case (area)
         iflsq_pkg::AREA_APP: begin
            if (exec_area_i == iflsq_pkg::IFLSQ_EXEC_APP && writes) begin
               access_ok = 1'b0;
            end
            if ({1'b0, addr16} >= APP_LIMIT) begin
               access_ok = 1'b0;
            end
         end
         iflsq_pkg::AREA_LOADER: begin
            if (exec_area_i == iflsq_pkg::IFLSQ_EXEC_APP && writes
                && !loader_update_enable_i) begin
               access_ok = 1'b0;
            end
            if (exec_area_i == iflsq_pkg::IFLSQ_EXEC_LOADER && writes) begin
               access_ok = 1'b0;
            end
            if ({1'b0, addr16} >= LOADER_LIMIT) begin
               access_ok = 1'b0;
            end
         end
         iflsq_pkg::AREA_CFG: begin
            if (exec_area_i != iflsq_pkg::IFLSQ_EXEC_LOADER) begin
               access_ok = 1'b0;
            end
            if (func == iflsq_pkg::FUNC_ERASE) begin
               if (addr_hi_reg != iflsq_pkg::ZERO_BYTE) begin
                  access_ok = 1'b0;
               end
            end else if ({1'b0, addr16} >= CFG_LIMIT) begin
               access_ok = 1'b0;
            end
         end
         default: begin
            access_ok = 1'b0;
         end
      endcase
   end

   assign refused = !access_ok || exec_area_i == iflsq_pkg::IFLSQ_EXEC_EXTERNAL;

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         IFLSQ_IDLE: begin
            if (trigger) begin
               state_next = IFLSQ_WAIT_OSC;
            end
         end
         IFLSQ_WAIT_OSC: begin
            if (rc_ready_reg) begin
               if (refused || standby || !known_func) begin
                  state_next = IFLSQ_FINISH;
               end else begin
                  state_next = IFLSQ_ACCESS;
               end
            end
         end
         IFLSQ_ACCESS: begin
            if (flash_done_i) begin
               state_next = IFLSQ_FINISH;
            end
         end
         IFLSQ_FINISH: begin
            state_next = IFLSQ_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_b_reg) begin
      if (!rst_b_reg) begin
         state_reg <= IFLSQ_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // CPU stays held from the trigger write through the finish cycle
   always_ff @(posedge clk_i or negedge rst_b_reg) begin
      if (!rst_b_reg) begin
         cpu_hold_o <= 1'b0;
      end else begin
         cpu_hold_o <= (state_next != IFLSQ_IDLE);
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_reg) begin
      if (!rst_b_reg) begin
         fault_reg <= 1'b0;
      end else if (state_reg == IFLSQ_WAIT_OSC && rc_ready_reg && refused
                   && !standby && known_func) begin
         fault_reg <= 1'b1;
      end else if (fault_clear_i) begin
         fault_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_reg) begin
      if (!rst_b_reg) begin
         cmd_reg <= iflsq_pkg::RESET_VAL;
      end else if (sfr_wr_i && hit(iflsq_pkg::CMD_OFS) && !cpu_hold_o) begin
         cmd_reg <= sfr_wdata_i;
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_reg) begin
      if (!rst_b_reg) begin
         addr_hi_reg <= iflsq_pkg::RESET_VAL;
      end else if (sfr_wr_i && hit(iflsq_pkg::ADDR_HI_OFS) && !cpu_hold_o) begin
         addr_hi_reg <= sfr_wdata_i;
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_reg) begin
      if (!rst_b_reg) begin
         addr_lo_reg <= iflsq_pkg::RESET_VAL;
      end else if (sfr_wr_i && hit(iflsq_pkg::ADDR_LO_OFS) && !cpu_hold_o) begin
         addr_lo_reg <= sfr_wdata_i;
      end
   end

   // read result lands in data byte
   always_ff @(posedge clk_i or negedge rst_b_reg) begin
      if (!rst_b_reg) begin
         data_reg <= iflsq_pkg::RESET_VAL;
      end else if (state_reg == IFLSQ_ACCESS && flash_done_i
                   && func == iflsq_pkg::FUNC_READ) begin
         data_reg <= flash_rdata_i;
      end else if (sfr_wr_i && hit(iflsq_pkg::DATA_OFS) && !cpu_hold_o) begin
         data_reg <= sfr_wdata_i;
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_reg) begin
      if (!rst_b_reg) begin
         sfr_rdata_o <= iflsq_pkg::RESET_VAL;
      end else if (sfr_rd_i) begin
         if (hit(iflsq_pkg::CMD_OFS)) begin
            sfr_rdata_o <= cmd_reg;
         end else if (hit(iflsq_pkg::ADDR_HI_OFS)) begin
            sfr_rdata_o <= addr_hi_reg;
         end else if (hit(iflsq_pkg::ADDR_LO_OFS)) begin
            sfr_rdata_o <= addr_lo_reg;
         end else if (hit(iflsq_pkg::DATA_OFS)) begin
            sfr_rdata_o <= data_reg;
         end else begin
            sfr_rdata_o <= iflsq_pkg::ZERO_BYTE;
         end
      end else begin
         sfr_rdata_o <= iflsq_pkg::ZERO_BYTE;
      end
   end

   // Flash array request, held for the whole access
   always_ff @(posedge clk_i or negedge rst_b_reg) begin
      if (!rst_b_reg) begin
         flash_req_o   <= 1'b0;
         flash_op_o    <= iflsq_pkg::IFLSQ_OP_READ;
         flash_addr_o  <= 18'h0_0000;
         flash_wdata_o <= iflsq_pkg::RESET_VAL;
      end else begin
         flash_req_o <= (state_next == IFLSQ_ACCESS);
         if (state_reg == IFLSQ_WAIT_OSC) begin
            unique case (func)
               iflsq_pkg::FUNC_ERASE:   flash_op_o <= iflsq_pkg::IFLSQ_OP_ERASE;
               iflsq_pkg::FUNC_PROGRAM: flash_op_o <= iflsq_pkg::IFLSQ_OP_PROGRAM;
               default:                 flash_op_o <= iflsq_pkg::IFLSQ_OP_READ;
            endcase
            if (func == iflsq_pkg::FUNC_ERASE) begin
               flash_addr_o <= {area, addr_hi_reg, iflsq_pkg::ZERO_BYTE};
            end else begin
               flash_addr_o <= {area, addr16};
            end
            flash_wdata_o <= data_reg;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_reg) begin
      if (!rst_b_reg) begin
         rc_osc_en_o    <= 1'b0;
         key_unlocked_o <= 1'b0;
      end else begin
         rc_osc_en_o    <= prog_enable_i;
         key_unlocked_o <= (key_stage_reg == 2'h2);
      end
   end

   assign programming_fault_flag_o = fault_reg;

   logic captured_reg;
   always_ff @(posedge clk_i or negedge rst_b_reg) begin
      if (!rst_b_reg) begin
         captured_reg  <= 1'b0;
      end else begin
         captured_reg  <= 1'b1;
      end
   end

   // Boot select kept across a soft reset; needs no async reset for that
   always_ff @(posedge clk_i) begin
      if (!captured_reg) begin
         cfg0_active_o <= cfg0_stored_i;
         if (soft_reset_cause_i) begin
            cfg0_active_o[iflsq_pkg::BOOT_BIT] <= cfg0_active_o[iflsq_pkg::BOOT_BIT];
         end
      end
   end
endmodule : iflsq_sequencer
`default_nettype wire

// ==== iflsq_pkg.sv ====
// Constants for the flash programming sequencer.
// Assumes an 8-bit special function register port on one clock.
package iflsq_pkg;
   // Register offsets on the SFR port, reset value and zero byte
   localparam logic [7:0] TRIG_OFS     = 8'hA4;
   localparam logic [7:0] ADDR_LO_OFS  = 8'hA6;
   localparam logic [7:0] ADDR_HI_OFS  = 8'hA7;
   localparam logic [7:0] DATA_OFS     = 8'hAE;
   localparam logic [7:0] CMD_OFS      = 8'hAF;
   localparam logic [7:0] KEY_OFS      = 8'hC7;
   localparam logic [7:0] RESET_VAL    = 8'h00;
   localparam logic [7:0] ZERO_BYTE    = 8'h00;
   // Timed-access key bytes
   localparam logic [7:0] KEY_FIRST    = 8'hAA;
   localparam logic [7:0] KEY_SECOND   = 8'h55;
   // Command register fields, trigger go bit, lock bit and cfg0 boot select bit
   localparam int AREA_HI    = 7;
   localparam int AREA_LO    = 6;
   localparam int OE_BIT     = 5;
   localparam int CE_BIT     = 4;
   localparam int FUNC_HI    = 3;
   localparam int FUNC_LO    = 0;
   localparam int GO_BIT     = 0;
   localparam int LOCK_BIT   = 1;
   localparam int BOOT_BIT   = 1;
   // Target areas
   localparam logic [1:0] AREA_APP    = 2'h0;
   localparam logic [1:0] AREA_LOADER = 2'h1;
   localparam logic [1:0] AREA_CFG    = 2'h3;
   // Function codes
   localparam logic [3:0] FUNC_READ    = 4'h0;
   localparam logic [3:0] FUNC_PROGRAM = 4'h1;
   localparam logic [3:0] FUNC_ERASE   = 4'h2;
   // Where the CPU is executing from
   typedef enum logic [1:0] {
      IFLSQ_EXEC_APP,
      IFLSQ_EXEC_LOADER,
      IFLSQ_EXEC_EXTERNAL
   } iflsq_exec_t;
   // Operation handed to the flash array
   typedef enum logic [1:0] {
      IFLSQ_OP_READ,
      IFLSQ_OP_PROGRAM,
      IFLSQ_OP_ERASE
   } iflsq_op_t;
endpackage : iflsq_pkg

// ==== iflsq_sequencer_asserts.sv ====
// Port checker for the flash programming sequencer.
// Bound to the sequencer top; one clock, checks start three edges after rst_b_i rises.
`timescale 1ns/1ps
`default_nettype none
module iflsq_sequencer_asserts (
   input wire logic                 clk_i,
   input wire logic                 rst_b_i,
   input wire logic [7:0]           sfr_addr_i,
   input wire logic [7:0]           sfr_wdata_i,
   input wire logic                 sfr_wr_i,
   input wire logic                 sfr_rd_i,
   input wire logic [7:0]           sfr_rdata_o,
   input wire logic                 prog_enable_i,
   input wire logic                 fault_clear_i,
   input wire logic                 rc_osc_en_o,
   input wire logic                 cpu_hold_o,
   input wire logic                 programming_fault_flag_o,
   input wire logic                 flash_req_o,
   input wire iflsq_pkg::iflsq_op_t flash_op_o,
   input wire logic [17:0]          flash_addr_o,
   input wire logic                 flash_done_i
);
   logic [1:0] up_reg;
   logic       key1_reg;
   logic       key2_reg;
   logic       trig_w;
   logic       key_w;
   assign trig_w = sfr_wr_i && sfr_addr_i == iflsq_pkg::TRIG_OFS;
   assign key_w = sfr_wr_i && sfr_addr_i == iflsq_pkg::KEY_OFS;
   // Design leaves reset two edges late
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) up_reg <= 2'h0;
      else if (up_reg != 2'h3) up_reg <= up_reg + 2'h1;
   end
   // Any other write disarms the key
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         key1_reg <= 1'b0;
         key2_reg <= 1'b0;
      end else if (sfr_wr_i) begin
         key1_reg <= key_w && sfr_wdata_i == iflsq_pkg::KEY_FIRST;
         key2_reg <= key1_reg && key_w && sfr_wdata_i == iflsq_pkg::KEY_SECOND;
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (up_reg != 2'h3);
   property p_trig_zero; sfr_rd_i && sfr_addr_i == 8'hA4 |=> sfr_rdata_o == 8'h00; endproperty
   a_trig_zero: assert property (p_trig_zero) else $error("trigger read not zero");
   property p_start;
      trig_w && sfr_wdata_i[0] && key2_reg && prog_enable_i && !cpu_hold_o |=> cpu_hold_o;
   endproperty
   a_start: assert property (p_start) else $error("trigger not taken");
   property p_locked; trig_w && !key2_reg && !cpu_hold_o |=> !cpu_hold_o; endproperty
   a_locked: assert property (p_locked) else $error("trigger without key");
   property p_req_in_hold; !cpu_hold_o |=> !flash_req_o; endproperty
   a_req_in_hold: assert property (p_req_in_hold) else $error("access while free");
   property p_done; flash_req_o && flash_done_i |=> !flash_req_o ##1 !cpu_hold_o; endproperty
   a_done: assert property (p_done) else $error("no release after done");
   property p_page;
      flash_req_o && flash_op_o == iflsq_pkg::IFLSQ_OP_ERASE |-> flash_addr_o[7:0] == 8'h00;
   endproperty
   a_page: assert property (p_page) else $error("erase not page aligned");
   property p_sticky; programming_fault_flag_o && !fault_clear_i |=> programming_fault_flag_o;
   endproperty
   a_sticky: assert property (p_sticky) else $error("fault flag lost");
   property p_osc; sfr_wr_i || !sfr_wr_i |=> rc_osc_en_o == $past(prog_enable_i); endproperty
   a_osc: assert property (p_osc) else $error("oscillator enable wrong");
   c_start: cover property (trig_w && key2_reg && prog_enable_i && !cpu_hold_o);
   c_fault: cover property ($rose(programming_fault_flag_o));
   c_erase: cover property (flash_req_o && flash_op_o == iflsq_pkg::IFLSQ_OP_ERASE);
endmodule // iflsq_sequencer_asserts
bind iflsq_sequencer iflsq_sequencer_asserts chk_u (
   .clk_i(clk_i), .rst_b_i(rst_b_i), .sfr_addr_i(sfr_addr_i), .sfr_wdata_i(sfr_wdata_i),
   .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .sfr_rdata_o(sfr_rdata_o),
   .prog_enable_i(prog_enable_i), .fault_clear_i(fault_clear_i), .rc_osc_en_o(rc_osc_en_o),
   .cpu_hold_o(cpu_hold_o), .programming_fault_flag_o(programming_fault_flag_o),
   .flash_req_o(flash_req_o), .flash_op_o(flash_op_o), .flash_addr_o(flash_addr_o),
   .flash_done_i(flash_done_i));
`default_nettype wire

// ==== iflsq_flash_model.sv ====
// Behavioural flash array for the sequencer's access port.
// One 256-byte page serves all areas; lat_i sets the answer delay.
`timescale 1ns/1ps
`default_nettype none
module iflsq_flash_model (
   input  wire logic                 clk_i,
   input  wire logic                 req_i,
   input  wire iflsq_pkg::iflsq_op_t op_i,
   input  wire logic [17:0]          addr_i,
   input  wire logic [7:0]           wdata_i,
   input  wire logic [3:0]           lat_i,
   output logic      [7:0]           rdata_o,
   output logic                      done_o
);
   logic [7:0] mem [256];
   logic [3:0] cnt = 4'h0;
   initial begin
      done_o = 1'b0;
      rdata_o = 8'h00;
      foreach (mem[i]) mem[i] = 8'hFF;
   end
   always @(posedge clk_i) begin
      done_o <= 1'b0;
      // Toggles so a stale capture shows
      rdata_o <= ~rdata_o;
      if (!req_i || done_o) cnt <= 4'h0;
      else if (cnt != lat_i) cnt <= cnt + 4'h1;
      else begin
         done_o <= 1'b1;
         if (op_i == iflsq_pkg::IFLSQ_OP_READ) rdata_o <= mem[addr_i[7:0]];
         else if (op_i == iflsq_pkg::IFLSQ_OP_PROGRAM)
            mem[addr_i[7:0]] <= mem[addr_i[7:0]] & wdata_i;
         else foreach (mem[i]) mem[i] <= 8'hFF;
      end
   end
endmodule // iflsq_flash_model
`default_nettype wire

// ==== iflsq_sequencer_tb_top.sv ====
// Self-checking bench for the flash programming sequencer.
// Assumes the flash model and the bound port checker.
`timescale 1ns/1ps
`default_nettype none
module iflsq_sequencer_tb_top;
   logic                   clk = 1'b0;
   logic                   rst_b = 1'b0;
   logic [7:0]             addr = 8'h00;
   logic [7:0]             wdata = 8'h00;
   logic                   wr_en = 1'b0;
   logic                   rd_en = 1'b0;
   logic                   prog_en = 1'b1;
   logic                   ldu = 1'b0;
   logic                   fclr = 1'b0;
   logic                   soft_rst = 1'b0;
   logic [7:0]             cfg_st = 8'h02;
   logic                   rc_rdy = 1'b0;
   logic [3:0]             lat = 4'h2;
   iflsq_pkg::iflsq_exec_t exec = iflsq_pkg::IFLSQ_EXEC_LOADER;
   iflsq_pkg::iflsq_op_t   op;
   iflsq_pkg::iflsq_op_t   last_op;
   logic [17:0]            faddr;
   logic [17:0]            last_addr;
   logic [7:0]             rdata, cfg, fwd, frd;
   logic                   osc, hold, flt, req, done, unl;
   int                     fail_count = 0;
   int                     total_checks = 0;
   int                     nreq = 0;
   int                     n0;
   logic [7:0] regs [5] = '{8'hA4, 8'hA6, 8'hA7, 8'hAE, 8'hAF};
   // Cases: command, address high, {exec, loader update, access, fault}
   // config erase last write
   logic [7:0] cc [15] = '{8'h21, 8'hC0, 8'h61, 8'h61, 8'h00, 8'h40, 8'h61,
                           8'hE2, 8'hC0, 8'h30, 8'h0F, 8'h00, 8'h80, 8'h40, 8'hE2};
   logic [7:0] ch [15] = '{0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 8'h20, 8'h01};
   logic [4:0] cf [15] = '{5'h01, 5'h01, 5'h01, 5'h06, 5'h02, 5'h0A, 5'h09,
                           5'h0A, 5'h0A, 5'h08, 5'h08, 5'h11, 5'h09, 5'h09, 5'h09};
   always #12.5 clk = ~clk;
   always @(posedge clk) rc_rdy <= osc;
   always @(posedge clk) begin
      if (req && done) begin
         nreq <= nreq + 1;
         last_op <= op;
         last_addr <= faddr;
      end
   end
   iflsq_sequencer dut_u (
      .clk_i(clk), .rst_b_i(rst_b), .sfr_addr_i(addr), .sfr_wdata_i(wdata),
      .sfr_wr_i(wr_en), .sfr_rd_i(rd_en), .sfr_rdata_o(rdata), .prog_enable_i(prog_en),
      .loader_update_enable_i(ldu), .fault_clear_i(fclr), .exec_area_i(exec),
      .soft_reset_cause_i(soft_rst), .cfg0_stored_i(cfg_st), .rc_ready_i(rc_rdy),
      .rc_osc_en_o(osc), .cpu_hold_o(hold), .programming_fault_flag_o(flt),
      .key_unlocked_o(unl), .cfg0_active_o(cfg), .flash_req_o(req), .flash_op_o(op),
      .flash_addr_o(faddr), .flash_wdata_o(fwd), .flash_rdata_i(frd), .flash_done_i(done));
   iflsq_flash_model flash_u (.clk_i(clk), .req_i(req), .op_i(op), .addr_i(faddr),
      .wdata_i(fwd), .lat_i(lat), .rdata_o(frd), .done_o(done));
   task automatic chk(input string nm, input logic [17:0] seen, exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, exp);
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1 chk("sfr_rdata_o", rdata, exp);
   endtask
   // Loads command and address, then unlocks and triggers
   // no interrupt source runs
   task automatic go(input logic [7:0] cmd, hi, input logic key);
      int n;
      wr(8'hAF, cmd);
      wr(8'hA7, hi);
      wr(8'hA6, 8'h03);
      if (key) wr(iflsq_pkg::KEY_OFS, iflsq_pkg::KEY_FIRST);
      wr(iflsq_pkg::KEY_OFS, iflsq_pkg::KEY_SECOND);
      wr(8'hA4, 8'h01);
      for (n = 0; n < 200; n++) begin
         @(posedge clk);
         #1;
         if (hold === 1'b0) break;
      end
      if (n == 200) begin
         fail_count++;
         final_report();
      end
   endtask
   initial begin
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge clk);
      chk("cfg0_active_o", cfg, 8'h02);
      foreach (regs[i]) rd(regs[i], 8'h00);
      rd(8'h10, 8'h00);
      wr(8'hA7, 8'hC3);
      wr(8'hA6, 8'h5A);
      wr(8'hAF, 8'hE5);
      rd(8'hA7, 8'hC3);
      rd(8'hA6, 8'h5A);
      rd(8'hAF, 8'hE5);
      wr(8'hAE, 8'h3C);
      go(8'h21, 8'h12, 1'b1);
      chk("flash_addr_o", last_addr, 18'h0_1203);
      chk("flash_op_o", last_op, iflsq_pkg::IFLSQ_OP_PROGRAM);
      wr(8'hAE, 8'h00);
      go(8'h00, 8'h12, 1'b1);
      rd(8'hAE, 8'h3C);
      go(8'h22, 8'h12, 1'b1);
      chk("flash_addr_o", last_addr, 18'h0_1200);
      go(8'h00, 8'h12, 1'b1);
      rd(8'hAE, 8'hFF);
      wr(iflsq_pkg::KEY_OFS, iflsq_pkg::KEY_FIRST);
      wr(iflsq_pkg::KEY_OFS, iflsq_pkg::KEY_SECOND);
      @(posedge clk);
      #1 chk("key_unlocked_o", unl, 1'b1);
      wr(8'hA6, 8'h03);
      @(posedge clk);
      #1 chk("key_unlocked_o", unl, 1'b0);
      n0 = nreq;
      go(8'h00, 8'h00, 1'b0);
      chk("access count", 18'(nreq - n0), 18'h0_0000);
      @(posedge clk);
      prog_en <= 1'b0;
      go(8'h00, 8'h00, 1'b1);
      chk("access count", 18'(nreq - n0), 18'h0_0000);
      chk("rc_osc_en_o", osc, 1'b0);
      @(posedge clk);
      prog_en <= 1'b1;
      for (int i = 0; i < 15; i++) begin
         @(posedge clk);
         exec <= iflsq_pkg::iflsq_exec_t'(cf[i][4:3]);
         ldu <= cf[i][2];
         lat <= 4'(i);
         n0 = nreq;
         go(cc[i], ch[i], 1'b1);
         chk("access made", 18'(nreq - n0), 18'(cf[i][1]));
         chk("fault flag", flt, cf[i][0]);
         @(posedge clk);
         fclr <= 1'b1;
         @(posedge clk);
         fclr <= 1'b0;
      end
      @(posedge clk);
      #1 chk("fault flag", flt, 1'b0);
      for (int i = 0; i < 2; i++) begin
         @(posedge clk);
         soft_rst <= (i == 0);
         cfg_st <= 8'h00;
         rst_b <= 1'b0;
         repeat (4) @(posedge clk);
         rst_b <= 1'b1;
         repeat (4) @(posedge clk);
         #1 chk("cfg0_active_o", cfg, (i == 0) ? 18'h0_0002 : 18'h0_0000);
      end
      final_report();
   end
endmodule // iflsq_sequencer_tb_top
`default_nettype wire
